// ### hw/sfcfe_consts.vh
// constants for the serial flash command front end
`ifndef SFCFE_CONSTS_VH
`define SFCFE_CONSTS_VH
`define SFCFE_OP_READ 8'h03
`define SFCFE_OP_FAST 8'h0b
`define SFCFE_OP_DOUT 8'h3b
`define SFCFE_OP_DIO 8'hbb
`define SFCFE_OP_PAGE_CLR 8'h81
`define SFCFE_OP_SECT_CLR 8'h20
`define SFCFE_OP_HALF_CLR 8'h52
`define SFCFE_OP_FULL_CLR 8'hd8
`define SFCFE_OP_CHIP_CLR_A 8'h60
`define SFCFE_OP_CHIP_CLR_B 8'hc7
`define SFCFE_OP_PAGE_WR 8'h02
`define SFCFE_OP_DUAL_WR 8'ha2
`define SFCFE_OP_LATCH_SET 8'h06
`define SFCFE_OP_LATCH_CLR 8'h04
`define SFCFE_OP_VOL_UNLOCK 8'h50
`define SFCFE_OP_SEC_CLR 8'h44
`define SFCFE_OP_SEC_WR 8'h42
`define SFCFE_OP_SEC_RD 8'h48
`define SFCFE_OP_STAT_LO 8'h05
`define SFCFE_OP_STAT_HI 8'h35
`define SFCFE_OP_CFG_RD 8'h15
`define SFCFE_OP_STAT_WR 8'h01
`define SFCFE_OP_CFG_WR 8'h31
`define SFCFE_ADDR_TOP 21'h1fffff
`define SFCFE_ADDR_BYTES 3'h3
`define SFCFE_BIT_LAST 3'h7
`define SFCFE_DUAL_LAST 3'h3
`define SFCFE_STAT_BUSY 0
`define SFCFE_STAT_LATCH 1
`endif

// ### hw/sfcfe_front_end.v
// command front end of a serial nor flash: spi decode, hold, dual i/o
`timescale 1ns/100ps
`include "sfcfe_consts.vh"
module sfcfe_front_end #(
    parameter ADDR_W = 21
) (
    input wire sys_clk,
    input wire reset,
    input wire chip_select_n,
    input wire serial_clock,
    input wire hold_n,
    input wire io_line0_in,
    output reg io_line0_out,
    output reg io_line0_oe,
    input wire io_line1_in,
    output reg io_line1_out,
    output reg io_line1_oe,
    input wire busy_flag,
    input wire [7:0] status_high,
    input wire [7:0] config_value,
    input wire region_protected,
    input wire [7:0] read_data,
    output reg read_req,
    output reg [ADDR_W-1:0] op_addr,
    output reg [7:0] op_code,
    output reg op_start,
    output reg [7:0] wr_data,
    output reg wr_data_valid,
    output reg [15:0] status_wr_data,
    output reg write_latch,
    output reg volatile_unlock,
    output reg standby
);
    // ------------------------------------------------------------
    // input synchronisation and edge detection
    // ------------------------------------------------------------
    wire [4:0] pins_s;
    sfcfe_sync #(.WIDTH(5), .INIT(5'h1f)) u_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in({chip_select_n, serial_clock, hold_n, io_line1_in, io_line0_in}),
        .sync_out(pins_s)
    );
    wire cs_s = pins_s[4];
    wire sck_s = pins_s[3];
    wire hold_s = pins_s[2];
    wire d1_s = pins_s[1];
    wire d0_s = pins_s[0];
    reg sck_d;
    reg cs_d;
    wire sck_rise = sck_s & ~sck_d;
    wire sck_fall = ~sck_s & sck_d;
    wire cs_fall = ~cs_s & cs_d;
    wire cs_rise = cs_s & ~cs_d;

    // ------------------------------------------------------------
    // opcode classes
    // ------------------------------------------------------------
    localparam ST_OPC = 6'h01;
    localparam ST_ADDR = 6'h02;
    localparam ST_DUMMY = 6'h04;
    localparam ST_DATA_IN = 6'h08;
    localparam ST_DATA_OUT = 6'h10;
    localparam ST_IGNORE = 6'h20;

    function is_dual_out;
        input [7:0] op;
        is_dual_out = (op == `SFCFE_OP_DOUT) || (op == `SFCFE_OP_DIO);
    endfunction

    function has_addr;
        input [7:0] op;
        has_addr = (op == `SFCFE_OP_READ) || (op == `SFCFE_OP_FAST) || is_dual_out(op) ||
                   (op == `SFCFE_OP_PAGE_CLR) || (op == `SFCFE_OP_SECT_CLR) ||
                   (op == `SFCFE_OP_HALF_CLR) || (op == `SFCFE_OP_FULL_CLR) ||
                   (op == `SFCFE_OP_PAGE_WR) || (op == `SFCFE_OP_DUAL_WR) ||
                   (op == `SFCFE_OP_SEC_CLR) || (op == `SFCFE_OP_SEC_WR) || (op == `SFCFE_OP_SEC_RD);
    endfunction

    function has_dummy;
        input [7:0] op;
        has_dummy = (op == `SFCFE_OP_FAST) || is_dual_out(op) || (op == `SFCFE_OP_SEC_RD);
    endfunction

    function is_stat_read;
        input [7:0] op;
        is_stat_read = (op == `SFCFE_OP_STAT_LO) || (op == `SFCFE_OP_STAT_HI) || (op == `SFCFE_OP_CFG_RD);
    endfunction

    function is_modify;
        input [7:0] op;
        is_modify = (op == `SFCFE_OP_PAGE_CLR) || (op == `SFCFE_OP_SECT_CLR) ||
                    (op == `SFCFE_OP_HALF_CLR) || (op == `SFCFE_OP_FULL_CLR) ||
                    (op == `SFCFE_OP_CHIP_CLR_A) || (op == `SFCFE_OP_CHIP_CLR_B) ||
                    (op == `SFCFE_OP_PAGE_WR) || (op == `SFCFE_OP_DUAL_WR) ||
                    (op == `SFCFE_OP_SEC_CLR) || (op == `SFCFE_OP_SEC_WR) ||
                    (op == `SFCFE_OP_STAT_WR) || (op == `SFCFE_OP_CFG_WR);
    endfunction

    function is_known;
        input [7:0] op;
        is_known = has_addr(op) || is_modify(op) || is_stat_read(op) ||
                   (op == `SFCFE_OP_LATCH_SET) || (op == `SFCFE_OP_LATCH_CLR) ||
                   (op == `SFCFE_OP_VOL_UNLOCK);
    endfunction

    function is_array_read;
        input [7:0] op;
        is_array_read = (op == `SFCFE_OP_READ) || (op == `SFCFE_OP_FAST) || is_dual_out(op);
    endfunction

    // ------------------------------------------------------------
    // hold tracking
    // ------------------------------------------------------------
    reg held;
    // state follows hold only while the clock is low (deselect clears it at once), so a hold edge during a high clock waits
    always @(posedge sys_clk) begin
        if (reset || cs_s) begin
            held <= 1'b0;
        end else if (!sck_s) begin
            held <= ~hold_s;
        end
    end

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    reg [5:0] state;
    reg [2:0] bit_cnt;
    reg [2:0] byte_cnt;
    reg [7:0] shift_in;
    reg [7:0] shift_out;
    reg dual_in;
    reg driving;
    reg [1:0] wr_bytes;
    reg on_boundary;
    reg fetch_wait;
    wire link_ok = ~cs_s & ~held;
    wire [2:0] bit_last = dual_in ? `SFCFE_DUAL_LAST : `SFCFE_BIT_LAST;
    wire [7:0] next_shift_in = dual_in ? {shift_in[5:0], d1_s, d0_s} : {shift_in[6:0], d0_s};
    wire byte_done = link_ok && sck_rise && (bit_cnt == bit_last);
    wire [7:0] status_low = {6'h00, write_latch, busy_flag};

    always @(posedge sys_clk) begin
        if (reset) begin
            sck_d <= 1'b0;
            cs_d <= 1'b1;
            state <= ST_OPC;
            bit_cnt <= 3'h0;
            byte_cnt <= 3'h0;
            shift_in <= 8'h00;
            shift_out <= 8'h00;
            dual_in <= 1'b0;
            driving <= 1'b0;
            wr_bytes <= 2'h0;
            on_boundary <= 1'b1;
            fetch_wait <= 1'b0;
            op_code <= 8'h00;
            op_addr <= {ADDR_W{1'b0}};
            op_start <= 1'b0;
            wr_data <= 8'h00;
            wr_data_valid <= 1'b0;
            status_wr_data <= 16'h0000;
            read_req <= 1'b0;
            write_latch <= 1'b0;
            volatile_unlock <= 1'b0;
            standby <= 1'b1;
            io_line0_out <= 1'b0;
            io_line1_out <= 1'b0;
            io_line0_oe <= 1'b0;
            io_line1_oe <= 1'b0;
        end else begin
            sck_d <= sck_s;
            cs_d <= cs_s;
            op_start <= 1'b0;
            wr_data_valid <= 1'b0;
            read_req <= 1'b0;
            // core answers one cycle after the request, so take the byte a cycle later
            fetch_wait <= read_req;
            if (cs_fall) begin
                state <= ST_OPC;
                bit_cnt <= 3'h0;
                byte_cnt <= 3'h0;
                dual_in <= 1'b0;
                wr_bytes <= 2'h0;
                on_boundary <= 1'b1;
                standby <= 1'b0;
            end
            if (cs_rise) begin
                driving <= 1'b0;
                standby <= 1'b1;
                // write-type commands only complete on a byte boundary
                if (on_boundary && state != ST_IGNORE && !busy_flag) begin
                    if (op_code == `SFCFE_OP_LATCH_SET && state == ST_DUMMY) begin
                        write_latch <= 1'b1;
                    end else if (op_code == `SFCFE_OP_LATCH_CLR && state == ST_DUMMY) begin
                        write_latch <= 1'b0;
                    end else if (op_code == `SFCFE_OP_VOL_UNLOCK && state == ST_DUMMY) begin
                        volatile_unlock <= 1'b1;
                    end else if (is_modify(op_code) && write_latch && (state == ST_DUMMY || state == ST_DATA_IN)) begin
                        if (!region_protected || op_code == `SFCFE_OP_STAT_WR || op_code == `SFCFE_OP_CFG_WR) begin
                            op_start <= 1'b1;
                            if (op_code == `SFCFE_OP_STAT_WR) begin
                                volatile_unlock <= 1'b0;
                            end
                        end
                        write_latch <= 1'b0;
                    end
                end
            end else if (link_ok && sck_rise && state != ST_IGNORE) begin
                shift_in <= next_shift_in;
                bit_cnt <= (bit_cnt == bit_last) ? 3'h0 : bit_cnt + 3'h1;
                on_boundary <= (bit_cnt == bit_last);
            end
            if (byte_done && state != ST_IGNORE) begin
                case (state)
                    ST_OPC: begin
                        op_code <= next_shift_in;
                        byte_cnt <= 3'h0;
                        if (!is_known(next_shift_in)) begin
                            state <= ST_IGNORE;
                            standby <= 1'b1;
                        end else if (busy_flag && is_array_read(next_shift_in)) begin
                            state <= ST_IGNORE;
                        end else if (has_addr(next_shift_in)) begin
                            state <= ST_ADDR;
                            dual_in <= (next_shift_in == `SFCFE_OP_DIO);
                        end else if (is_stat_read(next_shift_in)) begin
                            state <= ST_DATA_OUT;
                            shift_out <= (next_shift_in == `SFCFE_OP_STAT_LO) ? status_low :
                                         (next_shift_in == `SFCFE_OP_STAT_HI) ? status_high : config_value;
                            driving <= 1'b1;
                        end else if (next_shift_in == `SFCFE_OP_STAT_WR || next_shift_in == `SFCFE_OP_CFG_WR) begin
                            state <= ST_DATA_IN;
                        end else begin
                            // no-payload command: waits here for deselect
                            state <= ST_DUMMY;
                            byte_cnt <= 3'h7;
                        end
                    end
                    ST_ADDR: begin
                        op_addr <= {op_addr[ADDR_W-9:0], next_shift_in};
                        byte_cnt <= byte_cnt + 3'h1;
                        if (byte_cnt == `SFCFE_ADDR_BYTES - 3'h1) begin
                            if (has_dummy(op_code)) begin
                                state <= ST_DUMMY;
                            end else if (op_code == `SFCFE_OP_READ) begin
                                state <= ST_DATA_OUT;
                                read_req <= 1'b1;
                                driving <= 1'b1;
                            end else if (op_code == `SFCFE_OP_PAGE_WR || op_code == `SFCFE_OP_DUAL_WR ||
                                         op_code == `SFCFE_OP_SEC_WR) begin
                                state <= ST_DATA_IN;
                                dual_in <= (op_code == `SFCFE_OP_DUAL_WR);
                            end else begin
                                state <= ST_DUMMY;
                                byte_cnt <= 3'h7;
                            end
                        end
                    end
                    ST_DUMMY: begin
                        // a byte after a no-payload command is harmless; boundary still judged at deselect
                        if (byte_cnt != 3'h7) begin
                            state <= ST_DATA_OUT;
                            dual_in <= 1'b0;
                            read_req <= 1'b1;
                            driving <= 1'b1;
                        end
                    end
                    ST_DATA_IN: begin
                        wr_data <= next_shift_in;
                        wr_data_valid <= 1'b1;
                        status_wr_data <= {status_wr_data[7:0], next_shift_in};
                        wr_bytes <= (wr_bytes == 2'h3) ? wr_bytes : wr_bytes + 2'h1;
                    end
                    default: begin
                        state <= state;
                    end
                endcase
            end
            // output path: load a new byte after the last bit goes out
            if (state == ST_DATA_OUT && link_ok && sck_fall && driving) begin
                if (is_dual_out(op_code)) begin
                    io_line1_out <= shift_out[7];
                    io_line0_out <= shift_out[6];
                    shift_out <= {shift_out[5:0], 2'b00};
                end else begin
                    io_line1_out <= shift_out[7];
                    shift_out <= {shift_out[6:0], 1'b0};
                end
            end
            if (state == ST_DATA_OUT && byte_done) begin
                if (is_stat_read(op_code)) begin
                    shift_out <= (op_code == `SFCFE_OP_STAT_LO) ? status_low :
                                 (op_code == `SFCFE_OP_STAT_HI) ? status_high : config_value;
                end else begin
                    shift_out <= read_data;
                    read_req <= 1'b1;
                    op_addr <= (op_addr == `SFCFE_ADDR_TOP) ? {ADDR_W{1'b0}} : op_addr + 1'b1;
                end
            end
            if (state == ST_DATA_OUT && fetch_wait) begin
                shift_out <= read_data;
            end
            // byte counting for data-out uses the dual width too
            if (state == ST_DATA_OUT && is_dual_out(op_code) && !dual_in) begin
                dual_in <= 1'b1;
            end
            io_line1_oe <= driving && link_ok && state == ST_DATA_OUT;
            io_line0_oe <= driving && link_ok && state == ST_DATA_OUT && is_dual_out(op_code);
        end
    end
endmodule // sfcfe_front_end

// ### hw/sfcfe_sync.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module sfcfe_sync #(
    parameter WIDTH = 4,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
    input wire sys_clk,
    input wire reset,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;
    always @(posedge sys_clk) begin
        if (reset) begin
            stage1 <= INIT;
            sync_out <= INIT;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // sfcfe_sync

// ### tb/sfcfe_fe_assertions.sv
// concurrent checks on the serial flash command front end ports
`timescale 1ns/100ps
module sfcfe_fe_checker (
    input wire sys_clk,
    input wire reset,
    input wire chip_select_n,
    input wire serial_clock,
    input wire hold_n,
    input wire busy_flag,
    input wire region_protected,
    input wire io_line0_oe,
    input wire io_line1_out,
    input wire io_line1_oe,
    input wire read_req,
    input wire [7:0] op_code,
    input wire op_start,
    input wire write_latch,
    input wire standby
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    chk_deselect_quiet: assert property (chip_select_n [*6] |-> !io_line0_oe && !io_line1_oe)
        else $error("data line driven while deselected");
    chk_standby_quiet: assert property (standby && $past(standby) |-> !io_line0_oe && !io_line1_oe)
        else $error("data line driven in standby");
    chk_hold_quiet: assert property ((!hold_n && !serial_clock) [*6] |-> !io_line1_oe)
        else $error("output driven during hold");
    chk_start_deselected: assert property (op_start |-> $past(chip_select_n, 3))
        else $error("command started while still selected");
    chk_start_allowed: assert property (op_start |-> $past(write_latch) && !$past(busy_flag))
        else $error("command started without latch or while busy");
    chk_start_unprotected: assert property (op_start |-> !$past(region_protected))
        else $error("command started on protected region");
    chk_latch_drop: assert property (op_start |-> ##[0:2] !write_latch)
        else $error("latch kept after modifying command");
    chk_latch_cause: assert property ($rose(write_latch) |-> op_code == 8'h06)
        else $error("latch set by wrong opcode");
    chk_out_on_fall: assert property (io_line1_oe && $past(io_line1_oe) && $changed(io_line1_out)
        |-> $past(serial_clock, 3) == 1'b0)
        else $error("output bit changed away from falling clock");
    chk_read_idle: assert property (read_req |-> !standby && !$past(busy_flag))
        else $error("array fetch while idle or busy");
    cov_start: cover property (op_start);
    cov_read: cover property (read_req);
    cov_latch: cover property ($rose(write_latch));
    cov_standby: cover property (!chip_select_n && standby);
endmodule // sfcfe_fe_checker

bind sfcfe_front_end sfcfe_fe_checker u_chk (.sys_clk(sys_clk), .reset(reset), .chip_select_n(chip_select_n),
    .serial_clock(serial_clock), .hold_n(hold_n), .busy_flag(busy_flag), .region_protected(region_protected),
    .io_line0_oe(io_line0_oe), .io_line1_out(io_line1_out), .io_line1_oe(io_line1_oe), .read_req(read_req),
    .op_code(op_code), .op_start(op_start), .write_latch(write_latch), .standby(standby));

// ### tb/sfcfe_host_model.sv
// spi host model in mode 0 driving select, clock, hold and io_line0
`timescale 1ns/100ps
module sfcfe_host_model (
    input wire sys_clk,
    input wire io1_level,
    output logic chip_select_n,
    output logic serial_clock,
    output logic hold_n,
    output logic host_io0,
    output logic host_io1
);
    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    initial begin
        chip_select_n = 1'b1;
        serial_clock = 1'b0;
        hold_n = 1'b1;
        host_io0 = 1'b0;
        host_io1 = 1'b0;
    end
    // host toggles io_line1 whenever the front end leaves it undriven: a moving pattern exposes stale reads
    always @(negedge sys_clk) host_io1 <= ~host_io1;
    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            host_io0 = tx[i];
            wait_n(4);
            serial_clock = 1'b1;
            rx = {rx[6:0], io1_level};
            wait_n(4);
            serial_clock = 1'b0;
        end
    endtask
    task automatic select();
        wait_n(1);
        chip_select_n = 1'b0;
        wait_n(4);
    endtask
    task automatic deselect();
        wait_n(4);
        chip_select_n = 1'b1;
        host_io0 = ~host_io0;
        wait_n(8);
    endtask
    // hold edges only while the clock is low
    task automatic hold(input logic level);
        wait_n(2);
        hold_n = level;
        wait_n(8);
    endtask
endmodule // sfcfe_host_model

// ### tb/tb.sv
// self-checking bench for the serial flash command front end
`timescale 1ns/100ps
module tb;
    logic sys_clk, reset, busy_flag, region_protected;
    logic [7:0] read_data, status_high, config_value, rx, n_start, s;
    wire chip_select_n, serial_clock, hold_n, host_io0, host_io1;
    wire io_line0_out, io_line0_oe, io_line1_out, io_line1_oe, read_req, op_start, wr_data_valid;
    wire write_latch, volatile_unlock, standby;
    wire [20:0] op_addr;
    wire [7:0] op_code, wr_data;
    wire [15:0] status_wr_data;
    wire io_line0 = io_line0_oe ? io_line0_out : host_io0;
    wire io_line1 = io_line1_oe ? io_line1_out : host_io1;
    int n_mismatch = 0;
    int compares = 0;
    logic [7:0] ops [9] = '{8'h81, 8'h20, 8'h52, 8'hd8, 8'h44, 8'h02, 8'h42, 8'h60, 8'hc7};
    // ----------------------------------------
    // structure
    // ----------------------------------------
    sfcfe_front_end DUT (.sys_clk(sys_clk), .reset(reset), .chip_select_n(chip_select_n),
        .serial_clock(serial_clock), .hold_n(hold_n), .io_line0_in(io_line0), .io_line0_out(io_line0_out),
        .io_line0_oe(io_line0_oe), .io_line1_in(io_line1), .io_line1_out(io_line1_out), .io_line1_oe(io_line1_oe),
        .busy_flag(busy_flag), .status_high(status_high), .config_value(config_value),
        .region_protected(region_protected), .read_data(read_data), .read_req(read_req), .op_addr(op_addr),
        .op_code(op_code), .op_start(op_start), .wr_data(wr_data), .wr_data_valid(wr_data_valid),
        .status_wr_data(status_wr_data), .write_latch(write_latch), .volatile_unlock(volatile_unlock),
        .standby(standby));
    sfcfe_host_model host (.sys_clk(sys_clk), .io1_level(io_line1), .chip_select_n(chip_select_n),
        .serial_clock(serial_clock), .hold_n(hold_n), .host_io0(host_io0), .host_io1(host_io1));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // array model: byte is a fixed scramble of its address
    always @(posedge sys_clk) if (read_req === 1'b1) read_data <= op_addr[7:0] ^ 8'h5a;
    always @(posedge sys_clk) n_start <= reset ? 8'h00 : n_start + {7'h00, op_start === 1'b1};
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic open_cmd(input logic [7:0] op, input int n_addr, input logic [23:0] addr);
        host.select();
        host.shift(op, 8, rx);
        for (int i = 0; i < n_addr; i++) host.shift(addr[23 - 8 * i -: 8], 8, rx);
    endtask
    task automatic frame(input logic [7:0] op, input int n_addr, input logic [23:0] addr);
        open_cmd(op, n_addr, addr);
        host.deselect();
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_read();
        open_cmd(8'h03, 3, 24'h1ffffe);
        host.hold(1'b0);
        check("oe in hold", io_line1_oe, 1'b0);
        host.hold(1'b1);
        host.shift(8'h00, 8, rx);
        check("read byte 0", rx, 8'ha4);
        host.shift(8'h00, 8, rx);
        check("read byte 1", rx, 8'ha5);
        host.shift(8'h00, 3, rx);
        host.deselect();
        check("oe after cut read", io_line1_oe, 1'b0);
        open_cmd(8'h0b, 3, 24'h000021);
        host.shift(8'h00, 8, rx);
        host.shift(8'h00, 8, rx);
        host.deselect();
        check("fast read", rx, 8'h7b);
        open_cmd(8'h3b, 3, 24'h000010);
        host.shift(8'h00, 8, rx);
        for (int i = 0; i < 4; i++) begin
            host.shift(8'h00, 1, rx);
            s = {s[5:0], rx[0], io_line0};
        end
        host.deselect();
        check("dual read", s, 8'h4a);
    endtask
    task automatic t_status();
        open_cmd(8'h35, 0, 24'h0);
        host.shift(8'h00, 8, rx);
        host.deselect();
        check("high status", rx, status_high);
        open_cmd(8'h15, 0, 24'h0);
        host.shift(8'h00, 8, rx);
        host.deselect();
        check("config", rx, config_value);
    endtask
    task automatic t_latch();
        frame(8'h06, 0, 24'h0);
        check("latch set", write_latch, 1'b1);
        open_cmd(8'h05, 0, 24'h0);
        host.shift(8'h00, 8, rx);
        host.deselect();
        check("low status", rx[1:0], 2'b10);
        frame(8'h04, 0, 24'h0);
        check("latch clear", write_latch, 1'b0);
        frame(8'h50, 0, 24'h0);
        check("volatile unlock", volatile_unlock, 1'b1);
        s = n_start;
        frame(8'h20, 3, 24'h000000);
        check("start no latch", n_start, s);
        frame(8'h06, 0, 24'h0);
        open_cmd(8'h20, 3, 24'h001000);
        host.shift(8'h00, 3, rx);
        host.deselect();
        check("start partial byte", n_start, s);
        frame(8'h06, 0, 24'h0);
        busy_flag = 1'b1;
        frame(8'h20, 3, 24'h002000);
        busy_flag = 1'b0;
        check("start while busy", n_start, s);
        frame(8'h06, 0, 24'h0);
        region_protected = 1'b1;
        frame(8'h20, 3, 24'h003000);
        region_protected = 1'b0;
        check("start protected", n_start, s);
    endtask
    task automatic t_modify();
        for (int k = 0; k < 9; k++) begin
            s = n_start;
            frame(8'h06, 0, 24'h0);
            open_cmd(ops[k], (ops[k] == 8'h60 || ops[k] == 8'hc7) ? 0 : 3, 24'h1ff000 + k);
            if (ops[k] == 8'h02 || ops[k] == 8'h42) host.shift(8'h96, 8, rx);
            host.deselect();
            check("start", n_start, s + 8'h01);
            check("opcode", op_code, ops[k]);
            check("latch after op", write_latch, 1'b0);
            if (k < 7) check("address", op_addr, 21'h1ff000 + k);
            if (k == 5 || k == 6) check("data byte", wr_data, 8'h96);
        end
        frame(8'h06, 0, 24'h0);
        open_cmd(8'h01, 0, 24'h0);
        host.shift(8'hab, 8, rx);
        host.shift(8'hcd, 8, rx);
        host.deselect();
        check("status write", status_wr_data, 16'habcd);
        check("unlock after status write", volatile_unlock, 1'b0);
    endtask
    task automatic t_unknown();
        open_cmd(8'hee, 0, 24'h0);
        host.shift(8'h00, 8, rx);
        check("standby", standby, 1'b1);
        check("oe unknown op", io_line1_oe, 1'b0);
        host.deselect();
        frame(8'h06, 0, 24'h0);
        check("recovered", write_latch, 1'b1);
    endtask
    initial begin
        reset = 1'b1;
        busy_flag = 1'b0;
        region_protected = 1'b0;
        status_high = 8'hc3;
        config_value = 8'h3c;
        read_data = 8'h00;
        repeat (5) @(negedge sys_clk);
        reset = 1'b0;
        repeat (4) @(negedge sys_clk);
        t_read();
        t_status();
        t_latch();
        t_modify();
        t_unknown();
        conclude();
    end
    // run needs well under 1 ms; allow three
    initial begin
        #3000000;
        n_mismatch++;
        conclude();
    end
endmodule // tb
